// ==== rtl/flash_erase_write_control.sv ====
// Flash erase/write sequencer and data-bus memory decoder
// Rules this block works under; R5 and R11 fall to software
// [R1] Mass erase needs enable bit set, then key 0xAA to the command register.
// [R2] Mass erase refused unless the emulator port is enabled.
// [R3] Page erase: page number into page register, then key 0x55.
// [R4] Program write enable routes data stores to flash, else to data RAM.
// [R5] Software masks interrupts before write enable, clears it afterwards.
// [R6] Erased bytes read all ones; changing bytes needs a page erase first.
// [R7] Flash-mode store also writes the data RAM cell at that address.
// [R8] A configuration bit selects flash read pulse width; one saves current.
// [R9] Decode MPU RAM, engine data, config RAM, engine program, else flash.
// [R10] Engine program RAM accesses are blocked while the engine runs.
// [R11] Software loads engine memories from flash before starting the engine.
// [R12] Processor reads and writes engine data RAM over the data bus.
// [R13] Wrong key values or keys without preparation start no erase.
// [R14] Accesses to slow regions stall for their wait-state count.
module flash_erase_write_control (
  input  wire logic        i_ref_clk,       // System clock, 100 MHz
  input  wire logic        i_srst,          // Synchronous reset
  input  wire logic        i_sfr_wr,        // SFR write strobe
  input  wire logic [7:0]  i_sfr_addr,      // SFR address
  input  wire logic [7:0]  i_sfr_wdata,     // SFR write data
  output logic      [7:0]  o_sfr_rdata,     // SFR read data, registered
  input  wire logic        i_emulator_port, // Emulator port enabled, pin
  input  wire logic        i_engine_run,    // Compute engine running
  input  wire logic        i_pulse_width,   // Config RAM pulse width bit
  output logic             o_flash_pulse_width_select, // To flash macro
  output logic             o_mass_erase,    // Mass erase start pulse
  output logic             o_page_erase,    // Page erase start pulse
  output logic      [6:0]  o_erase_page,    // Page to erase
  input  wire logic        i_bus_req,       // Data bus request, level
  input  wire logic        i_bus_we,        // Request is a store
  input  wire logic [15:0] i_bus_addr,      // Data bus address
  input  wire logic [7:0]  i_bus_wdata,     // Store data
  output logic      [7:0]  o_bus_rdata,     // Load data
  output logic             o_bus_done,      // Access finished, pulse
  output logic             o_bus_blocked,   // Access refused, pulse
  output logic             o_flash_prog,    // Flash program pulse
  output logic             o_mem_en,        // Memory strobe, level
  output logic             o_mem_we,        // Memory write
  output logic      [2:0]  o_mem_sel,       // Region select
  output logic      [15:0] o_mem_addr,      // Memory address
  output logic      [7:0]  o_mem_wdata,     // Memory write data
  input  wire logic [7:0]  i_mem_rdata      // Memory read data
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    flash_ctl_pkg::bus_state_t st;
    logic        mass_erase_enable;
    logic        program_write_enable;
    logic [6:0]  page;
    logic        page_armed;
    logic        emu_meta;
    logic        emu_sync;
    logic [7:0]  sfr_rdata;
    logic        mass_erase;
    logic        page_erase;
    logic        flash_prog;
    logic        pw_sel;
    logic        mem_en;
    logic        mem_we;
    logic [2:0]  mem_sel;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  bus_rdata;
    logic        bus_done;
    logic        bus_blocked;
  } ctl_t;

  ctl_t       state_reg;
  ctl_t       state_next;
  logic       timer_start;
  logic [2:0] wait_count;
  logic [2:0] region;
  logic       timer_expired;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Flash answers wherever no RAM claims the address
  always_comb begin
    region     = flash_ctl_pkg::REGION_FLASH;
    wait_count = flash_ctl_pkg::FLASH_WAIT;
    if (i_bus_addr <= flash_ctl_pkg::MPU_RAM_LAST) begin
      region     = flash_ctl_pkg::REGION_MPU_RAM; // R9
      wait_count = flash_ctl_pkg::MPU_RAM_WAIT;
    end else if (i_bus_addr >= flash_ctl_pkg::ENGINE_DATA_BASE &&
                 i_bus_addr <= flash_ctl_pkg::ENGINE_DATA_LAST) begin
      region     = flash_ctl_pkg::REGION_ENGINE_DATA; // R12
      wait_count = flash_ctl_pkg::ENGINE_DATA_WAIT;
    end else if (i_bus_addr >= flash_ctl_pkg::CONFIG_RAM_BASE &&
                 i_bus_addr <= flash_ctl_pkg::CONFIG_RAM_LAST) begin
      region     = flash_ctl_pkg::REGION_CONFIG_RAM; // R9
      wait_count = flash_ctl_pkg::CONFIG_RAM_WAIT;
    end else if (i_bus_addr >= flash_ctl_pkg::ENGINE_PROG_BASE &&
                 i_bus_addr <= flash_ctl_pkg::ENGINE_PROG_LAST) begin
      region     = flash_ctl_pkg::REGION_ENGINE_PROG; // R9
      wait_count = flash_ctl_pkg::ENGINE_PROG_WAIT;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Erase keys, control register, and bus sequencing
  always_comb begin
    state_next             = state_reg;
    state_next.mass_erase  = 1'b0;
    state_next.page_erase  = 1'b0;
    state_next.flash_prog  = 1'b0;
    state_next.bus_done    = 1'b0;
    state_next.bus_blocked = 1'b0;
    timer_start            = 1'b0;
    // Emulator pin is asynchronous; two stages before use
    state_next.emu_meta    = i_emulator_port;
    state_next.emu_sync    = state_reg.emu_meta;
    state_next.pw_sel      = i_pulse_width; // R8
    if (i_sfr_wr) begin
      unique case (i_sfr_addr)
        flash_ctl_pkg::FLASH_PROGRAM_CONTROL_ADDR: begin
          state_next.mass_erase_enable =
            i_sfr_wdata[flash_ctl_pkg::MASS_ERASE_ENABLE_BIT];
          state_next.program_write_enable =
            i_sfr_wdata[flash_ctl_pkg::PROGRAM_WRITE_ENABLE_BIT]; // R4
        end
        flash_ctl_pkg::ERASE_PAGE_NUMBER_ADDR: begin
          state_next.page       = i_sfr_wdata[7:flash_ctl_pkg::PAGE_FIELD_LSB];
          state_next.page_armed = 1'b1; // R3
        end
        flash_ctl_pkg::ERASE_COMMAND_KEY_ADDR: begin
          // Keys are one-shot; a wrong pattern disarms nothing but acts not
          if (i_sfr_wdata == flash_ctl_pkg::MASS_ERASE_KEY &&
              state_reg.mass_erase_enable && state_reg.emu_sync) begin
            state_next.mass_erase        = 1'b1; // R1 R2 R6
            state_next.mass_erase_enable = 1'b0;
          end else if (i_sfr_wdata == flash_ctl_pkg::PAGE_ERASE_KEY &&
                       state_reg.page_armed) begin
            state_next.page_erase = 1'b1; // R3 R6
            state_next.page_armed = 1'b0;
          end // R13
        end
        default: begin
        end
      endcase
    end
    // Read-back of the control and page registers
    unique case (i_sfr_addr)
      flash_ctl_pkg::FLASH_PROGRAM_CONTROL_ADDR:
        state_next.sfr_rdata = {6'h00, state_next.mass_erase_enable,
                                state_next.program_write_enable};
      flash_ctl_pkg::ERASE_PAGE_NUMBER_ADDR:
        state_next.sfr_rdata = {state_next.page, 1'b0};
      default:
        state_next.sfr_rdata = 8'h00;
    endcase
    unique case (state_reg.st)
      flash_ctl_pkg::BUS_IDLE: begin
        if (i_bus_req) begin
          state_next.mem_addr  = i_bus_addr;
          state_next.mem_wdata = i_bus_wdata;
          state_next.mem_sel   = region;
          state_next.mem_we    = i_bus_we;
          if (region == flash_ctl_pkg::REGION_ENGINE_PROG &&
              i_engine_run) begin
            state_next.st          = flash_ctl_pkg::BUS_DONE; // R10
            state_next.bus_done    = 1'b1;
            state_next.bus_blocked = 1'b1;
            state_next.bus_rdata   = 8'h00;
            state_next.mem_we      = 1'b0;
          end else begin
            state_next.st     = flash_ctl_pkg::BUS_ACCESS;
            state_next.mem_en = 1'b1;
            timer_start       = 1'b1; // R14
            // Store in program mode also lands in the RAM cell underneath
            state_next.flash_prog =
              i_bus_we && state_reg.program_write_enable; // R4 R7
          end
        end
      end
      flash_ctl_pkg::BUS_ACCESS: begin
        if (timer_expired) begin
          state_next.st        = flash_ctl_pkg::BUS_DONE; // R14
          state_next.mem_en    = 1'b0;
          state_next.mem_we    = 1'b0;
          state_next.bus_done  = 1'b1;
          state_next.bus_rdata = i_mem_rdata; // R12
        end
      end
      flash_ctl_pkg::BUS_DONE: begin
        state_next.st = flash_ctl_pkg::BUS_IDLE;
      end
      default: begin
        state_next.st = flash_ctl_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg    <= '0;
      state_reg.st <= flash_ctl_pkg::BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wait-state timing for every granted access
  wait_state_timer u_wait (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_start   (timer_start),
    .i_count   (wait_count),
    .o_expired (timer_expired)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_sfr_rdata                = state_reg.sfr_rdata;
  assign o_flash_pulse_width_select = state_reg.pw_sel;
  assign o_mass_erase               = state_reg.mass_erase;
  assign o_page_erase               = state_reg.page_erase;
  assign o_erase_page               = state_reg.page;
  assign o_bus_rdata                = state_reg.bus_rdata;
  assign o_bus_done                 = state_reg.bus_done;
  assign o_bus_blocked              = state_reg.bus_blocked;
  assign o_flash_prog               = state_reg.flash_prog;
  assign o_mem_en                   = state_reg.mem_en;
  assign o_mem_we                   = state_reg.mem_we;
  assign o_mem_sel                  = state_reg.mem_sel;
  assign o_mem_addr                 = state_reg.mem_addr;
  assign o_mem_wdata                = state_reg.mem_wdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic key_wr;
  logic accept;
  assign key_wr = i_sfr_wr &&
                  i_sfr_addr == flash_ctl_pkg::ERASE_COMMAND_KEY_ADDR;
  assign accept = state_reg.st == flash_ctl_pkg::BUS_IDLE && i_bus_req;

  sequence accept_slow_s;
    accept && wait_count == flash_ctl_pkg::ENGINE_DATA_WAIT &&
    !(region == flash_ctl_pkg::REGION_ENGINE_PROG && i_engine_run);
  endsequence
  sequence accept_fast_s;
    accept && wait_count == flash_ctl_pkg::FLASH_WAIT;
  endsequence

  // Key with enable only counts once the emulator pin is seen synced
  mass_erase_key_a: assert property ( // R1 R2
    @(posedge i_ref_clk) disable iff (i_srst)
    key_wr && i_sfr_wdata == flash_ctl_pkg::MASS_ERASE_KEY &&
    state_reg.mass_erase_enable && state_reg.emu_sync |=> o_mass_erase)
    else $error("mass erase key with enable did not start erase");
  mass_erase_emu_a: assert property ( // R2
    @(posedge i_ref_clk) disable iff (i_srst)
    o_mass_erase |-> $past(state_reg.emu_sync))
    else $error("mass erase started without emulator port");
  page_erase_key_a: assert property ( // R3
    @(posedge i_ref_clk) disable iff (i_srst)
    o_page_erase |-> $past(key_wr) && $past(state_reg.page_armed) &&
    $past(i_sfr_wdata) == flash_ctl_pkg::PAGE_ERASE_KEY)
    else $error("page erase without armed page and key");
  bad_key_a: assert property ( // R13
    @(posedge i_ref_clk) disable iff (i_srst)
    key_wr && i_sfr_wdata != flash_ctl_pkg::MASS_ERASE_KEY &&
    i_sfr_wdata != flash_ctl_pkg::PAGE_ERASE_KEY
    |=> !o_mass_erase && !o_page_erase)
    else $error("erase started by a wrong key");
  store_route_a: assert property ( // R4 R7
    @(posedge i_ref_clk) disable iff (i_srst)
    o_mem_en && !$past(o_mem_en) && o_mem_we
    |-> o_flash_prog == state_reg.program_write_enable)
    else $error("store routing does not follow write enable");
  engine_block_a: assert property ( // R10
    @(posedge i_ref_clk) disable iff (i_srst)
    accept && region == flash_ctl_pkg::REGION_ENGINE_PROG && i_engine_run
    |=> o_bus_blocked && !o_mem_en ##1 !o_mem_en)
    else $error("engine program RAM reached while engine runs");
  // Strobe stands ws+2 cycles, done follows on the next one
  slow_wait_a: assert property ( // R14 R12
    @(posedge i_ref_clk) disable iff (i_srst)
    accept_slow_s |=> (o_mem_en && !o_bus_done) [*7] ##1 o_bus_done)
    else $error("slow region access not stalled five wait states");
  fast_wait_a: assert property ( // R9 R14
    @(posedge i_ref_clk) disable iff (i_srst)
    accept_fast_s |=> o_mem_en ##1 o_mem_en ##1 o_bus_done)
    else $error("zero wait access did not finish in two cycles");
  pulse_width_a: assert property ( // R8
    @(posedge i_ref_clk) disable iff (i_srst)
    ##1 o_flash_pulse_width_select == $past(i_pulse_width))
    else $error("pulse width select not following config bit");
endmodule : flash_erase_write_control

// ==== rtl/flash_ctl_pkg.sv ====
// Constants and types shared by the flash erase/write sequencer
package flash_ctl_pkg;
  // ****************************************************************
  // Special function register addresses and keys
  // ****************************************************************
  localparam logic [7:0] ERASE_COMMAND_KEY_ADDR     = 8'h94;
  localparam logic [7:0] FLASH_PROGRAM_CONTROL_ADDR = 8'hB2;
  localparam logic [7:0] ERASE_PAGE_NUMBER_ADDR     = 8'hB7;
  localparam logic [7:0] MASS_ERASE_KEY             = 8'hAA;
  localparam logic [7:0] PAGE_ERASE_KEY             = 8'h55;
  localparam int         PROGRAM_WRITE_ENABLE_BIT   = 0;
  localparam int         MASS_ERASE_ENABLE_BIT      = 1;
  localparam int         PAGE_FIELD_LSB             = 1;
  localparam logic [7:0] ERASED_BYTE                = 8'hFF;

  // ****************************************************************
  // Data bus regions and wait states
  // ****************************************************************
  localparam logic [15:0] MPU_RAM_BASE     = 16'h0000;
  localparam logic [15:0] MPU_RAM_LAST     = 16'h07FF;
  localparam logic [15:0] ENGINE_DATA_BASE = 16'h1000;
  localparam logic [15:0] ENGINE_DATA_LAST = 16'h13FF;
  localparam logic [15:0] CONFIG_RAM_BASE  = 16'h2000;
  localparam logic [15:0] CONFIG_RAM_LAST  = 16'h20FF;
  localparam logic [15:0] ENGINE_PROG_BASE = 16'h3000;
  localparam logic [15:0] ENGINE_PROG_LAST = 16'h3FFF;
  localparam logic [2:0]  MPU_RAM_WAIT     = 3'h0;
  localparam logic [2:0]  ENGINE_DATA_WAIT = 3'h5;
  localparam logic [2:0]  CONFIG_RAM_WAIT  = 3'h0;
  localparam logic [2:0]  ENGINE_PROG_WAIT = 3'h5;
  localparam logic [2:0]  FLASH_WAIT       = 3'h0;

  // Region select codes on the memory strobe
  typedef enum logic [2:0] {
    REGION_FLASH       = 3'b000,
    REGION_MPU_RAM     = 3'b001,
    REGION_ENGINE_DATA = 3'b010,
    REGION_CONFIG_RAM  = 3'b011,
    REGION_ENGINE_PROG = 3'b100
  } region_t;

  // Data bus access sequencer
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ACCESS = 2'b01,
    BUS_DONE   = 2'b10
  } bus_state_t;
endpackage : flash_ctl_pkg

// ==== rtl/wait_state_timer.sv ====
// Wait-state down counter that flags the end of a memory access
module wait_state_timer (
  input  wire logic       i_ref_clk, // System clock
  input  wire logic       i_srst,    // Synchronous reset, active high
  input  wire logic       i_start,   // Load the count, one-cycle pulse
  input  wire logic [2:0] i_count,   // Wait states to insert
  output logic            o_expired  // Count exhausted, one-cycle pulse
);
  typedef struct packed {
    logic       busy;
    logic [2:0] cnt;
    logic       expired;
  } timer_t;

  timer_t state_reg;
  timer_t state_next;

  // Count down once per cycle, pulse on reaching zero
  always_comb begin
    state_next         = state_reg;
    state_next.expired = 1'b0;
    if (i_start) begin
      state_next.busy = 1'b1;
      state_next.cnt  = i_count;
    end else if (state_reg.busy) begin
      if (state_reg.cnt == 3'h0) begin
        state_next.busy    = 1'b0;
        state_next.expired = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt - 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_expired = state_reg.expired;
endmodule : wait_state_timer

// ==== test/mem_array_model.sv ====
// Behavioural memory behind the sequencer's data-bus strobe
module mem_array_model (
  input  wire logic        i_ref_clk,   // System clock
  input  wire logic        i_mem_en,    // Memory strobe
  input  wire logic        i_mem_we,    // Memory write
  input  wire logic [15:0] i_mem_addr,  // Memory address
  input  wire logic [7:0]  i_mem_wdata, // Memory write data
  output logic      [7:0]  o_mem_rdata  // Memory read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  logic [7:0] last_reg = 8'h00;
  // ****************************************************************
  // Contents
  // ****************************************************************
  // Seed pattern, so a load never matches by luck of a default value
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8];
    end
  end
  // Store on every strobed write cycle; remember the last value driven
  always @(posedge i_ref_clk) begin
    if (i_mem_en && i_mem_we) begin
      mem[i_mem_addr] <= i_mem_wdata;
    end
    if (i_mem_en) begin
      last_reg <= mem[i_mem_addr];
    end
  end
  // Released bus shows the inverse, never a stale copy
  assign o_mem_rdata = i_mem_en ? mem[i_mem_addr] : ~last_reg;
endmodule : mem_array_model

// ==== test/tb_top.sv ====
// Self-checking bench for the flash erase/write sequencer
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk       = 1'b0;
  logic        i_srst          = 1'b1;
  logic        i_sfr_wr        = 1'b0;
  logic [7:0]  i_sfr_addr      = 8'h00;
  logic [7:0]  i_sfr_wdata     = 8'h00;
  logic        i_emulator_port = 1'b0;
  logic        i_engine_run    = 1'b0;
  logic        i_pulse_width   = 1'b0;
  logic        i_bus_req       = 1'b0;
  logic        i_bus_we        = 1'b0;
  logic [15:0] i_bus_addr      = 16'h0000;
  logic [7:0]  i_bus_wdata     = 8'h00;
  logic [7:0]  i_mem_rdata;
  logic [7:0]  o_sfr_rdata;
  logic        o_flash_pulse_width_select;
  logic        o_mass_erase;
  logic        o_page_erase;
  logic [6:0]  o_erase_page;
  logic [7:0]  o_bus_rdata;
  logic        o_bus_done;
  logic        o_bus_blocked;
  logic        o_flash_prog;
  logic        o_mem_en;
  logic        o_mem_we;
  logic [2:0]  o_mem_sel;
  logic [15:0] o_mem_addr;
  logic [7:0]  o_mem_wdata;
  int          miscompares = 0;
  int          check_count = 0;
  int          mass_cnt    = 0;
  int          page_cnt    = 0;
  int          prog_cnt    = 0;
  int          exp_mem [int];

  // ****************************************************************
  // Clock, design and far-side memory
  // ****************************************************************
  always #5 i_ref_clk = ~i_ref_clk;

  flash_erase_write_control u_flash_erase_write_control (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_sfr_wr(i_sfr_wr),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_emulator_port(i_emulator_port),
    .i_engine_run(i_engine_run), .i_pulse_width(i_pulse_width),
    .o_flash_pulse_width_select(o_flash_pulse_width_select),
    .o_mass_erase(o_mass_erase), .o_page_erase(o_page_erase),
    .o_erase_page(o_erase_page), .i_bus_req(i_bus_req),
    .i_bus_we(i_bus_we), .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
    .o_bus_done(o_bus_done), .o_bus_blocked(o_bus_blocked),
    .o_flash_prog(o_flash_prog), .o_mem_en(o_mem_en),
    .o_mem_we(o_mem_we), .o_mem_sel(o_mem_sel),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata));

  mem_array_model u_mem_array_model (
    .i_ref_clk(i_ref_clk), .i_mem_en(o_mem_en), .i_mem_we(o_mem_we),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .o_mem_rdata(i_mem_rdata));

  // Tally pulses; a refusal shows as a missing count
  always @(posedge i_ref_clk) begin
    mass_cnt += int'(o_mass_erase === 1'b1);
    page_cnt += int'(o_page_erase === 1'b1);
    prog_cnt += int'(o_flash_prog === 1'b1);
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Write strobe for one cycle, then let any pulse land
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_wr    <= 1'b1;
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    @(posedge i_ref_clk);
    i_sfr_wr    <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : sfr_wr

  // Read data is registered one cycle after the address
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    repeat (2) @(posedge i_ref_clk);
    #1;
    d = o_sfr_rdata;
  endtask : sfr_rd

  // One data-bus access held until done, checked against the model
  task automatic bus_xfer(input logic we, input logic [15:0] a,
                          input int ws, input int sel, input logic blk);
    logic [7:0] d;
    logic [2:0] s;
    logic       en1;
    logic       w1;
    logic [15:0] a1;
    logic [7:0] wd1;
    int         n;
    int         ex;
    d = 8'($urandom());
    n = 0;
    @(posedge i_ref_clk);
    i_bus_req   <= 1'b1;
    i_bus_we    <= we;
    i_bus_addr  <= a;
    i_bus_wdata <= d;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (n == 1) begin
        s   = o_mem_sel;
        en1 = o_mem_en;
        w1  = o_mem_we;
        a1  = o_mem_addr;
        wd1 = o_mem_wdata;
      end
    end while (o_bus_done !== 1'b1 && n < 20);
    ex = exp_mem.exists(a) ? exp_mem[a] : int'(a[7:0] ^ a[15:8]);
    `CHK("latency", blk ? 1 : ws + 3, n)
    `CHK("blocked", blk, o_bus_blocked)
    `CHK("strobe", !blk, en1)
    `CHK("mem_addr", a, a1)
    `CHK("mem_we", !blk && we, w1)
    if (!blk) begin
      `CHK("region", sel, s)
    end
    if (!blk && we) begin
      `CHK("mem_wdata", d, wd1)
      exp_mem[a] = d;
    end
    if (!we) begin
      `CHK("load_data", blk ? 0 : ex, o_bus_rdata)
    end
    @(posedge i_ref_clk);
    i_bus_req <= 1'b0;
  endtask : bus_xfer

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Whole run is about two hundred cycles; this leaves wide margin
  initial begin
    #200us;
    miscompares++;
    close_out();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0]  r;
    logic [6:0]  pg;
    logic [15:0] a;
    int base [5] = '{16'h0000, 16'h1000, 16'h2008, 16'h3000, 16'h8000};
    int span [5] = '{16'h0800, 16'h0400, 16'h00F8, 16'h1000, 16'h8000};
    int wst  [5] = '{0, 5, 0, 5, 0};
    void'($urandom(45));
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    sfr_rd(8'hB2, r);
    `CHK("ctl_reset", 8'h00, r)
    sfr_rd(8'hB7, r);
    `CHK("page_reset", 8'h00, r)
    // Keyed mass erase, first with the emulator port off
    sfr_wr(8'hB2, 8'h02);
    sfr_wr(8'h94, 8'hAA);
    `CHK("mass_no_emu", 0, mass_cnt)
    i_emulator_port <= 1'b1;
    sfr_wr(8'hB2, 8'h02);
    sfr_wr(8'h94, 8'hAA);
    `CHK("mass_erase", 1, mass_cnt)
    sfr_rd(8'hB2, r);
    `CHK("enable_clear", 8'h00, r)
    sfr_wr(8'h94, 8'hAA);
    `CHK("mass_unarmed", 1, mass_cnt)
    // Page erase on a random page, a wrong key first
    pg = 7'($urandom());
    sfr_wr(8'hB7, {pg, 1'b0});
    sfr_rd(8'hB7, r);
    `CHK("page_read", {pg, 1'b0}, r)
    sfr_wr(8'h94, 8'h33);
    `CHK("bad_key", 0, page_cnt)
    sfr_wr(8'h94, 8'h55);
    `CHK("page_erase", 1, page_cnt)
    `CHK("erase_page", pg, o_erase_page)
    sfr_wr(8'h94, 8'h55);
    `CHK("page_unarmed", 1, page_cnt)
    // Read pulse width bit follows config with one cycle delay
    for (int k = 0; k < 4; k++) begin
      @(posedge i_ref_clk);
      i_pulse_width <= k[0];
      @(posedge i_ref_clk);
      #1;
      `CHK("pulse_width", k[0], o_flash_pulse_width_select)
    end
    // Store then load a random address in every region
    for (int i = 0; i < 5; i++) begin
      a = 16'(base[i] + $urandom_range(span[i] - 1));
      bus_xfer(1'b1, a, wst[i], (i + 1) % 5, 1'b0);
      bus_xfer(1'b0, a, wst[i], (i + 1) % 5, 1'b0);
    end
    // Engine program RAM shut while the engine runs
    i_engine_run <= 1'b1;
    bus_xfer(1'b0, 16'h3004, 5, 4, 1'b1);
    bus_xfer(1'b1, 16'h3008, 5, 4, 1'b1);
    bus_xfer(1'b0, 16'h1010, 5, 2, 1'b0);
    i_engine_run <= 1'b0;
    bus_xfer(1'b0, 16'h3008, 5, 4, 1'b0);
    // Interrupts are taken as masked by software before this
    `CHK("no_prog", 0, prog_cnt)
    sfr_wr(8'hB2, 8'h01);
    bus_xfer(1'b1, 16'h9000, 0, 0, 1'b0);
    `CHK("flash_prog", 1, prog_cnt)
    sfr_wr(8'hB2, 8'h00);
    bus_xfer(1'b0, 16'h9000, 0, 0, 1'b0);
    bus_xfer(1'b1, 16'h9001, 0, 0, 1'b0);
    `CHK("ram_store", 1, prog_cnt)
    close_out();
  end
endmodule : tb_top
